// file: rtl/logic_cell_config_regs.sv
// Configurable logic cell with its register bank and interrupt flag.
// Assumes a register master that honours one-cycle strobes and synchronous
// source inputs on mclk.
//
// Summary of operation
// - Enable clear forces cell output to zero
// - Control status bit reads output after inversion
// - Enabled rising output edge sets irq flag
// - Enabled falling output edge sets irq flag
// - Modes 000-010 are combinational functions; 011 is an SR latch
// - Modes 100-111 are flip-flops and latch
// - Output invert bit inverts function result
// - Gate invert bits invert each gate result
// - Unimplemented control and polarity bits read zero
// - Four six-bit data source selectors
// - Gate select holds true/inverted enables per input
// - Control and output invert reset to zero
// - Selects and gate bits survive resets
// - Gate with no inputs equals its invert bit
// - Edge during flag clear keeps flag set
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps

module logic_cell_config_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [cell_pkg::SOURCE_COUNT-1:0] source_in,
    output logic cell_output,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
                                     input logic [3:0] index);
        return strobe && (addr == index);
    endfunction : reg_hit

    // Control word to its writable fields; bits 6 and 5 are dropped
    function automatic cell_pkg::control_t ctrl_from_word(input logic [7:0] word);
        cell_pkg::control_t c;
        c.cell_enable = word[cell_pkg::CTRL_ENABLE_BIT];
        c.rise_irq_enable = word[cell_pkg::CTRL_RISE_BIT];
        c.fall_irq_enable = word[cell_pkg::CTRL_FALL_BIT];
        c.function_select = cell_pkg::function_t'(word[2:0]);
        return c;
    endfunction : ctrl_from_word

    // Gate: OR of enabled true/inverted inputs, then polarity
    function automatic logic gate_eval(input logic [7:0] sel, input logic [3:0] d,
                                       input logic inv);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 4; k++) begin
            hit = hit | (sel[2*k+1] & d[k]) | (sel[2*k] & ~d[k]);
        end
        return hit ^ inv;
    endfunction : gate_eval

    ////////////////////////////////////////////////////////////////////////////
    // State

    cell_pkg::cell_state_t st_reg;
    cell_pkg::cell_state_t st_next;
    logic [3:0] data_in;
    logic [3:0] gate_val;
    logic logic_res;
    logic gate_a_rise;
    logic rise_event;
    logic fall_event;
    logic flag_clear;
    logic [7:0] read_word;

    ////////////////////////////////////////////////////////////////////////////
    // Data selection and gating

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign data_in[gi] = source_in[st_reg.data_source[gi]];
            assign gate_val[gi] = gate_eval(st_reg.gate_select[gi], data_in,
                                            st_reg.gate_invert[gi]);
        end
    endgenerate

    assign gate_a_rise = gate_val[0] & ~st_reg.gate_a_prev;
    assign flag_clear = reg_hit(reg_write, reg_addr, cell_pkg::ADDR_IRQ_STATUS)
                        && reg_wdata[cell_pkg::IRQ_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        read_word = 8'h00;
        if (reg_addr == cell_pkg::ADDR_CONTROL) begin
            read_word[cell_pkg::CTRL_ENABLE_BIT] = st_reg.ctrl.cell_enable;
            read_word[cell_pkg::CTRL_STATUS_BIT] = st_reg.cell_out;
            read_word[cell_pkg::CTRL_RISE_BIT] = st_reg.ctrl.rise_irq_enable;
            read_word[cell_pkg::CTRL_FALL_BIT] = st_reg.ctrl.fall_irq_enable;
            read_word[2:0] = st_reg.ctrl.function_select;
        end else if (reg_addr == cell_pkg::ADDR_POLARITY) begin
            read_word[cell_pkg::POL_OUTPUT_BIT] = st_reg.output_invert;
            read_word[3:0] = st_reg.gate_invert;
        end else if (reg_addr == cell_pkg::ADDR_SEL_ONE) begin
            read_word[5:0] = st_reg.data_source[0];
        end else if (reg_addr == cell_pkg::ADDR_SEL_TWO) begin
            read_word[5:0] = st_reg.data_source[1];
        end else if (reg_addr == cell_pkg::ADDR_SEL_THREE) begin
            read_word[5:0] = st_reg.data_source[2];
        end else if (reg_addr == cell_pkg::ADDR_SEL_FOUR) begin
            read_word[5:0] = st_reg.data_source[3];
        end else if (reg_addr == cell_pkg::ADDR_GATE_A) begin
            read_word = st_reg.gate_select[0];
        end else if (reg_addr == cell_pkg::ADDR_GATE_B) begin
            read_word = st_reg.gate_select[1];
        end else if (reg_addr == cell_pkg::ADDR_GATE_C) begin
            read_word = st_reg.gate_select[2];
        end else if (reg_addr == cell_pkg::ADDR_GATE_D) begin
            read_word = st_reg.gate_select[3];
        end else if (reg_addr == cell_pkg::ADDR_IRQ_STATUS) begin
            read_word[cell_pkg::IRQ_FLAG_BIT] = st_reg.irq_flag;
        end else if (reg_addr == cell_pkg::ADDR_IRQ_MASK) begin
            read_word[cell_pkg::IRQ_FLAG_BIT] = st_reg.irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;
        logic_res = 1'b0;
        rise_event = 1'b0;
        fall_event = 1'b0;

        // Register writes
        if (reg_write) begin
            if (reg_addr == cell_pkg::ADDR_CONTROL) begin
                st_next.ctrl = ctrl_from_word(reg_wdata);
            end else if (reg_addr == cell_pkg::ADDR_POLARITY) begin
                st_next.output_invert = reg_wdata[cell_pkg::POL_OUTPUT_BIT];
                st_next.gate_invert = reg_wdata[3:0];
            end else if (reg_addr == cell_pkg::ADDR_SEL_ONE) begin
                st_next.data_source[0] = reg_wdata[5:0];
            end else if (reg_addr == cell_pkg::ADDR_SEL_TWO) begin
                st_next.data_source[1] = reg_wdata[5:0];
            end else if (reg_addr == cell_pkg::ADDR_SEL_THREE) begin
                st_next.data_source[2] = reg_wdata[5:0];
            end else if (reg_addr == cell_pkg::ADDR_SEL_FOUR) begin
                st_next.data_source[3] = reg_wdata[5:0];
            end else if (reg_addr == cell_pkg::ADDR_GATE_A) begin
                st_next.gate_select[0] = reg_wdata;
            end else if (reg_addr == cell_pkg::ADDR_GATE_B) begin
                st_next.gate_select[1] = reg_wdata;
            end else if (reg_addr == cell_pkg::ADDR_GATE_C) begin
                st_next.gate_select[2] = reg_wdata;
            end else if (reg_addr == cell_pkg::ADDR_GATE_D) begin
                st_next.gate_select[3] = reg_wdata;
            end else if (reg_addr == cell_pkg::ADDR_IRQ_MASK) begin
                st_next.irq_mask = reg_wdata[cell_pkg::IRQ_FLAG_BIT];
            end
        end

        // Logic function; gate a is the clock in modes 100-110 and the latch enable in 111
        case (st_reg.ctrl.function_select)
            cell_pkg::FN_AND_OR: begin
                logic_res = (gate_val[0] & gate_val[1]) | (gate_val[2] & gate_val[3]);
            end
            cell_pkg::FN_OR_XOR: begin
                logic_res = (gate_val[0] | gate_val[1]) ^ (gate_val[2] | gate_val[3]);
            end
            cell_pkg::FN_AND4: begin
                logic_res = &gate_val;
            end
            cell_pkg::FN_SR_LATCH: begin
                if (gate_val[0] | gate_val[1]) begin
                    st_next.cell_q = 1'b1;
                end else if (gate_val[2] | gate_val[3]) begin
                    st_next.cell_q = 1'b0;
                end
                logic_res = st_next.cell_q;
            end
            cell_pkg::FN_DFF_SR: begin
                if (gate_val[2]) begin
                    st_next.cell_q = 1'b0;
                end else if (gate_val[3]) begin
                    st_next.cell_q = 1'b1;
                end else if (gate_a_rise) begin
                    st_next.cell_q = gate_val[1];
                end
                logic_res = st_next.cell_q;
            end
            cell_pkg::FN_DFF2_R: begin
                if (gate_val[2]) begin
                    st_next.cell_q = 1'b0;
                end else if (gate_a_rise) begin
                    st_next.cell_q = gate_val[1] & gate_val[3];
                end
                logic_res = st_next.cell_q;
            end
            cell_pkg::FN_JK_R: begin
                if (gate_val[2]) begin
                    st_next.cell_q = 1'b0;
                end else if (gate_a_rise) begin
                    case ({gate_val[1], gate_val[3]})
                        2'b10: st_next.cell_q = 1'b1;
                        2'b01: st_next.cell_q = 1'b0;
                        2'b11: st_next.cell_q = ~st_reg.cell_q;
                        default: st_next.cell_q = st_reg.cell_q;
                    endcase
                end
                logic_res = st_next.cell_q;
            end
            default: begin
                if (gate_val[2]) begin
                    st_next.cell_q = 1'b0;
                end else if (gate_val[3]) begin
                    st_next.cell_q = 1'b1;
                end else if (gate_val[0]) begin
                    st_next.cell_q = gate_val[1];
                end
                logic_res = st_next.cell_q;
            end
        endcase
        st_next.gate_a_prev = gate_val[0];

        // Output stage; a disabled cell holds zero
        if (st_reg.ctrl.cell_enable) begin
            st_next.cell_out = logic_res ^ st_reg.output_invert;
        end else begin
            st_next.cell_out = 1'b0;
            st_next.cell_q = 1'b0;
        end

        // Edge detect against the previous sample
        rise_event = st_next.cell_out & ~st_reg.cell_out;
        fall_event = ~st_next.cell_out & st_reg.cell_out;

        // Clear first, so a same-cycle edge wins
        if (flag_clear) begin
            st_next.irq_flag = 1'b0;
        end
        if ((rise_event && st_reg.ctrl.rise_irq_enable) ||
            (fall_event && st_reg.ctrl.fall_irq_enable)) begin
            st_next.irq_flag = 1'b1;
        end

        st_next.irq = st_next.irq_flag & st_next.irq_mask;
        st_next.rdata = reg_read ? read_word : 8'h00;

        // Selects and gate bits are left alone by reset
        if (rst) begin
            st_next.ctrl = ctrl_from_word(cell_pkg::CONTROL_RESET);
            st_next.output_invert = cell_pkg::OUTPUT_INVERT_RESET;
            st_next.irq_flag = 1'b0;
            st_next.irq_mask = 1'b0;
            st_next.cell_q = 1'b0;
            st_next.gate_a_prev = 1'b0;
            st_next.cell_out = 1'b0;
            st_next.irq = 1'b0;
            st_next.rdata = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    assign reg_rdata = st_reg.rdata;
    assign cell_output = st_reg.cell_out;
    assign irq = st_reg.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (rst);

    AST_DISABLED_ZERO: assert property (
        !st_reg.ctrl.cell_enable |=> !cell_output [*2]
        or (!cell_output ##1 $past(st_reg.ctrl.cell_enable)))
    else $error("cell output high while disabled");

    AST_STATUS_READ: assert property (
        reg_read && reg_addr == cell_pkg::ADDR_CONTROL
        |=> reg_rdata[cell_pkg::CTRL_STATUS_BIT] == $past(cell_output))
    else $error("status bit does not match cell output");

    AST_RISE_SETS: assert property (
        $rose(cell_output) && $past(st_reg.ctrl.rise_irq_enable) |-> st_reg.irq_flag)
    else $error("enabled rising edge did not set flag");

    AST_RISE_MASKED: assert property (
        $rose(cell_output) && !$past(st_reg.ctrl.rise_irq_enable) && !$past(st_reg.irq_flag)
        |-> !st_reg.irq_flag)
    else $error("disabled rising edge set flag");

    AST_FALL_SETS: assert property (
        $fell(cell_output) && $past(st_reg.ctrl.fall_irq_enable) |-> st_reg.irq_flag)
    else $error("enabled falling edge did not set flag");

    AST_FALL_MASKED: assert property (
        $fell(cell_output) && !$past(st_reg.ctrl.fall_irq_enable) && !$past(st_reg.irq_flag)
        |-> !st_reg.irq_flag)
    else $error("disabled falling edge set flag");

    AST_AND4_MODE: assert property (
        st_reg.ctrl.cell_enable && st_reg.ctrl.function_select == cell_pkg::FN_AND4
        |=> cell_output == ($past(&gate_val) ^ $past(st_reg.output_invert)))
    else $error("four-input and result wrong");

    AST_AND_OR_MODE: assert property (
        st_reg.ctrl.cell_enable && st_reg.ctrl.function_select == cell_pkg::FN_AND_OR
        |=> cell_output == ($past((gate_val[0] & gate_val[1]) | (gate_val[2] & gate_val[3]))
                            ^ $past(st_reg.output_invert)))
    else $error("and-or result wrong");

    AST_DFF_CAPTURE: assert property (
        st_reg.ctrl.cell_enable && st_reg.ctrl.function_select == cell_pkg::FN_DFF_SR
        && gate_a_rise && !gate_val[2] && !gate_val[3]
        |=> cell_output == ($past(gate_val[1]) ^ $past(st_reg.output_invert)))
    else $error("d flip-flop capture wrong");

    AST_JK_TOGGLE: assert property (
        st_reg.ctrl.cell_enable && st_reg.ctrl.function_select == cell_pkg::FN_JK_R
        && gate_a_rise && !gate_val[2] && gate_val[1] && gate_val[3]
        |=> cell_output == (~$past(st_reg.cell_q) ^ $past(st_reg.output_invert)))
    else $error("j-k toggle wrong");

    AST_EMPTY_GATE: assert property (
        st_reg.gate_select[0] == 8'h00 |-> gate_val[0] == st_reg.gate_invert[0])
    else $error("empty gate differs from its invert bit");

    AST_RESERVED_ZERO: assert property (
        reg_read && reg_addr != cell_pkg::ADDR_GATE_A && reg_addr != cell_pkg::ADDR_GATE_B
        && reg_addr != cell_pkg::ADDR_GATE_C && reg_addr != cell_pkg::ADDR_GATE_D
        |=> reg_rdata[6] == 1'b0)
    else $error("unimplemented bit reads one");

    AST_CLEAR_RACE: assert property (
        flag_clear && rise_event && st_reg.ctrl.rise_irq_enable |=> st_reg.irq_flag)
    else $error("edge lost during flag clear");

    AST_FLAG_HOLD: assert property (
        st_reg.irq_flag && !flag_clear |=> st_reg.irq_flag)
    else $error("flag cleared without a clear write");

    AST_RESET_CLEAR: assert property (
        @(posedge mclk) disable iff (1'b0)
        rst |=> st_reg.ctrl == ctrl_from_word(cell_pkg::CONTROL_RESET)
                && !st_reg.output_invert && !cell_output)
    else $error("control not cleared by reset");

    AST_IRQ_LEVEL: assert property (
        st_reg.irq_flag && st_reg.irq_mask |-> irq)
    else $error("interrupt output low with unmasked flag");

    COV_RISE_IRQ: cover property ($rose(cell_output) ##0 st_reg.irq_flag ##1 irq);
    COV_JK_MODE: cover property (st_reg.ctrl.function_select == cell_pkg::FN_JK_R
                                 && gate_a_rise ##1 cell_output);
    COV_CLEAR_RACE: cover property (flag_clear && rise_event && st_reg.ctrl.rise_irq_enable);
    COV_STATUS_READ: cover property (reg_read && reg_addr == cell_pkg::ADDR_CONTROL
                                     && cell_output);
    COV_DFF2_MODE: cover property (st_reg.ctrl.function_select == cell_pkg::FN_DFF2_R
                                   && gate_a_rise ##1 cell_output);

endmodule : logic_cell_config_regs

// file: shared/cell_pkg.sv
// Package for the configurable logic cell register bank.
// Assumes an 8-bit register port and one system clock.
package cell_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_POLARITY = 4'h1;
    localparam logic [3:0] ADDR_SEL_ONE = 4'h2;
    localparam logic [3:0] ADDR_SEL_TWO = 4'h3;
    localparam logic [3:0] ADDR_SEL_THREE = 4'h4;
    localparam logic [3:0] ADDR_SEL_FOUR = 4'h5;
    localparam logic [3:0] ADDR_GATE_A = 4'h6;
    localparam logic [3:0] ADDR_GATE_B = 4'h7;
    localparam logic [3:0] ADDR_GATE_C = 4'h8;
    localparam logic [3:0] ADDR_GATE_D = 4'h9;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'ha;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hb;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_STATUS_BIT = 5;
    localparam int CTRL_RISE_BIT = 4;
    localparam int CTRL_FALL_BIT = 3;
    localparam int POL_OUTPUT_BIT = 7;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int SOURCE_WIDTH = 6;
    localparam int SOURCE_COUNT = 64;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic OUTPUT_INVERT_RESET = 1'b0;

    typedef enum logic [2:0] {
        FN_AND_OR = 3'b000,
        FN_OR_XOR = 3'b001,
        FN_AND4 = 3'b010,
        FN_SR_LATCH = 3'b011,
        FN_DFF_SR = 3'b100,
        FN_DFF2_R = 3'b101,
        FN_JK_R = 3'b110,
        FN_LATCH_SR = 3'b111
    } function_t;

    typedef struct packed {
        logic cell_enable;
        logic rise_irq_enable;
        logic fall_irq_enable;
        function_t function_select;
    } control_t;

    typedef struct packed {
        control_t ctrl;
        logic output_invert;
        logic [3:0] gate_invert;
        logic [3:0][SOURCE_WIDTH-1:0] data_source;
        logic [3:0][7:0] gate_select;
        logic irq_flag;
        logic irq_mask;
        logic cell_q;
        logic gate_a_prev;
        logic cell_out;
        logic irq;
        logic [7:0] rdata;
    } cell_state_t;

endpackage : cell_pkg

// file: tb/testbench.sv
// Self-checking bench for the logic cell register bank.
// Assumes the cell timing and the register map of the package.
`timescale 1ns/10ps

module testbench;
    logic mclk;
    logic rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic [cell_pkg::SOURCE_COUNT-1:0] source_in;
    logic cell_output;
    logic irq;
    int error_cnt;
    int comparisons;

    logic_cell_config_regs i_dut (
        .mclk(mclk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .source_in(source_in),
        .cell_output(cell_output),
        .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] addr, input logic [7:0] exp);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= addr;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd

    // Lets a register or source change reach the output and irq
    task automatic settle_out(input logic exp_out, input logic exp_irq);
        repeat (3) @(posedge mclk);
        #1;
        check({7'h00, cell_output}, {7'h00, exp_out});
        check({7'h00, irq}, {7'h00, exp_irq});
    endtask : settle_out

    task automatic wrap_up;
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic reset_and_map;
        rd(cell_pkg::ADDR_CONTROL, 8'h00);
        wr(cell_pkg::ADDR_POLARITY, 8'h0f);
        rd(cell_pkg::ADDR_POLARITY, 8'h0f);
        wr(cell_pkg::ADDR_CONTROL, 8'h7f);
        rd(cell_pkg::ADDR_CONTROL, 8'h1f);
        wr(cell_pkg::ADDR_POLARITY, 8'h7a);
        rd(cell_pkg::ADDR_POLARITY, 8'h0a);
        for (int k = 0; k < 4; k++) begin
            wr(cell_pkg::ADDR_SEL_ONE + 4'(k), 8'hc0 | 8'(k + 8'h21));
            rd(cell_pkg::ADDR_SEL_ONE + 4'(k), 8'(k + 8'h21));
        end
        wr(cell_pkg::ADDR_GATE_A, 8'ha5);
        rd(cell_pkg::ADDR_GATE_A, 8'ha5);
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00);
        rd(cell_pkg::ADDR_CONTROL, 8'h1f);
    endtask : reset_and_map

    task automatic retain_across_reset;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(cell_pkg::ADDR_SEL_ONE, 8'h21);
        rd(cell_pkg::ADDR_GATE_A, 8'ha5);
        rd(cell_pkg::ADDR_CONTROL, 8'h00);
        rd(cell_pkg::ADDR_POLARITY, 8'h0a);
    endtask : retain_across_reset

    task automatic modes_and_enable;
        logic [3:0] exp_tab;
        exp_tab = 4'b1101;
        for (int k = 4; k < 10; k++) begin
            wr(4'(k), 8'h00);
        end
        wr(cell_pkg::ADDR_POLARITY, 8'h0f);
        settle_out(1'b0, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr(cell_pkg::ADDR_CONTROL, 8'h80 | 8'(m));
            settle_out(exp_tab[m], 1'b0);
        end
        rd(cell_pkg::ADDR_CONTROL, 8'ha3);
        wr(cell_pkg::ADDR_POLARITY, 8'h8f);
        settle_out(1'b0, 1'b0);
        rd(cell_pkg::ADDR_CONTROL, 8'h83);
        wr(cell_pkg::ADDR_POLARITY, 8'h00);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_CONTROL, 8'h82);
        settle_out(1'b0, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h80);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_CONTROL, 8'h02);
        settle_out(1'b0, 1'b0);
    endtask : modes_and_enable

    // Gates are constants from their invert bits; gate a clocks the flip-flop
    task automatic sequential_dff;
        wr(cell_pkg::ADDR_POLARITY, 8'h02);
        wr(cell_pkg::ADDR_CONTROL, 8'h84);
        settle_out(1'b0, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h03);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h07);
        settle_out(1'b0, 1'b0);
        // J-K: two toggles with J and K high
        wr(cell_pkg::ADDR_CONTROL, 8'h86);
        wr(cell_pkg::ADDR_POLARITY, 8'h0a);
        wr(cell_pkg::ADDR_POLARITY, 8'h0b);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h0a);
        wr(cell_pkg::ADDR_POLARITY, 8'h0b);
        settle_out(1'b0, 1'b0);
        // Two-input flip-flop: d is gate b and gate d
        wr(cell_pkg::ADDR_CONTROL, 8'h85);
        wr(cell_pkg::ADDR_POLARITY, 8'h0a);
        wr(cell_pkg::ADDR_POLARITY, 8'h0b);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h02);
        wr(cell_pkg::ADDR_POLARITY, 8'h03);
        settle_out(1'b0, 1'b0);
        // Latch: open while gate a is high, then closed
        wr(cell_pkg::ADDR_CONTROL, 8'h87);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h01);
        settle_out(1'b0, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h02);
        settle_out(1'b0, 1'b0);
    endtask : sequential_dff

    task automatic data_path;
        wr(cell_pkg::ADDR_SEL_ONE, 8'h25);
        wr(cell_pkg::ADDR_SEL_FOUR, 8'h05);
        wr(cell_pkg::ADDR_GATE_A, 8'h02);
        wr(cell_pkg::ADDR_POLARITY, 8'h0e);
        wr(cell_pkg::ADDR_CONTROL, 8'h82);
        @(posedge mclk);
        source_in[37] <= 1'b1;
        settle_out(1'b1, 1'b0);
        @(posedge mclk);
        source_in[37] <= 1'b0;
        settle_out(1'b0, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h0f);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h0e);
        wr(cell_pkg::ADDR_GATE_A, 8'h40);
        settle_out(1'b1, 1'b0);
        @(posedge mclk);
        source_in[5] <= 1'b1;
        settle_out(1'b0, 1'b0);
    endtask : data_path

    task automatic interrupts;
        wr(cell_pkg::ADDR_CONTROL, 8'h00);
        wr(cell_pkg::ADDR_GATE_A, 8'h00);
        wr(cell_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(cell_pkg::ADDR_IRQ_MASK, 8'h01);
        wr(cell_pkg::ADDR_POLARITY, 8'h0f);
        wr(cell_pkg::ADDR_CONTROL, 8'h92);
        settle_out(1'b1, 1'b1);
        rd(cell_pkg::ADDR_IRQ_STATUS, 8'h01);
        repeat (4) @(posedge mclk);
        rd(cell_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(cell_pkg::ADDR_IRQ_STATUS, 8'h01);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h8f);
        settle_out(1'b0, 1'b0);
        wr(cell_pkg::ADDR_CONTROL, 8'h8a);
        wr(cell_pkg::ADDR_POLARITY, 8'h0f);
        settle_out(1'b1, 1'b0);
        wr(cell_pkg::ADDR_POLARITY, 8'h8f);
        settle_out(1'b0, 1'b1);
        wr(cell_pkg::ADDR_IRQ_MASK, 8'h00);
        settle_out(1'b0, 1'b0);
        rd(cell_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(cell_pkg::ADDR_IRQ_STATUS, 8'h01);
        rd(cell_pkg::ADDR_IRQ_STATUS, 8'h00);
    endtask : interrupts

    // Clear write and a rising edge in one cycle; the edge wins
    task automatic irq_clear_race;
        wr(cell_pkg::ADDR_CONTROL, 8'h92);
        wr(cell_pkg::ADDR_GATE_A, 8'h02);
        wr(cell_pkg::ADDR_POLARITY, 8'h0e);
        wr(cell_pkg::ADDR_IRQ_MASK, 8'h01);
        settle_out(1'b0, 1'b0);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= cell_pkg::ADDR_IRQ_STATUS;
        reg_wdata <= 8'h01;
        source_in[37] <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        settle_out(1'b1, 1'b1);
        rd(cell_pkg::ADDR_IRQ_STATUS, 8'h01);
    endtask : irq_clear_race

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and hang guard
    initial begin
        error_cnt = 0;
        comparisons = 0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        source_in = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        reset_and_map();
        retain_across_reset();
        modes_and_enable();
        sequential_dff();
        data_path();
        interrupts();
        irq_clear_race();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
endmodule : testbench
